// file: logic/mbd_decoder.sv
// Purpose: Binary register message decoder, with text messages passed on.
// Assumes: rx bytes on clk; rx dropped while rx_busy_r; tx drained by tx_ready.
// Notes: One message handled at a time; the reply leaves before the next is taken.
module mbd_decoder
  import mbd_pkg::*;
#(
  parameter int NREGS = REG_COUNT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Incoming bytes
  input wire mbd_byte_t rx,
  output logic rx_busy_r,
  // Reply bytes
  output mbd_byte_t tx_r,
  input wire logic tx_ready,
  // Text messages to the text handler
  output mbd_byte_t txt_r,
  // Control state
  input wire logic local_lock,
  output logic remote_r,
  output logic output_on_r
);
  typedef enum logic [2:0] {S_IDLE, S_RX, S_TXT, S_CHK, S_WR, S_TX} mbd_state_t;

  mbd_state_t state_r, state_nxt;
  logic [7:0] fbuf [MAX_FRAME];
  logic [8:0] len_r;
  logic ovf_r;
  logic [15:0] rx_crc, tx_crc;
  logic [7:0] fc, cnt, err, err_r;
  logic [15:0] start, num, fdata, wr_n_r, wr_i_r;
  logic [16:0] end_adr;
  logic [8:0] exp_len, rsp_len_r, tx_i_r, wp_r, didx;
  logic drop, fc_known, is_read, ok, take, load, tx_done, wr_last;
  logic reg_we;
  logic [15:0] reg_waddr, reg_wdata, reg_raddr, reg_rdata, rd_word;
  logic [7:0] tx_byte;
  logic rd_flag_val;

  assign fc = fbuf[OFS_FC];
  assign start = {fbuf[OFS_ADR], fbuf[OFS_ADR+1]};
  assign num = {fbuf[OFS_NUM], fbuf[OFS_NUM+1]};
  assign fdata = num;
  assign cnt = fbuf[OFS_CNT];
  assign end_adr = {1'b0, start} + {1'b0, num};
  assign fc_known = fc == FC_RD_FLAG || fc == FC_RD_BLK || fc == FC_WR_FLAG
                    || fc == FC_WR_WORD || fc == FC_WR_BLK;
  assign is_read = fc == FC_RD_FLAG || fc == FC_RD_BLK;
  assign exp_len = (fc == FC_WR_BLK) ? 9'(OFS_DAT) + 9'(cnt) + 9'(CRC_LEN) : 9'(FIX_LEN);
  assign take = rx.vld && (state_r == S_IDLE || state_r == S_RX || state_r == S_TXT);
  assign ok = state_r == S_CHK && !drop && err == ERR_NONE;
  assign load = !tx_r.vld || tx_ready;
  assign tx_done = state_r == S_TX && tx_i_r == rsp_len_r && load;
  assign wr_last = wr_i_r == wr_n_r - 16'h0001;

  //////////////////////////////////////////////////////////////////////////////
  // Checksums and register store

  mbd_crc u_rx_crc (
    .clk(clk),
    .rst(rst),
    .clr(state_r == S_CHK),
    .en(take && state_r != S_TXT && !(state_r == S_IDLE && rx.dat >= TEXT_MIN)),
    .din(rx.dat),
    .crc_r(rx_crc)
  );

  // Checksum bytes themselves stay out of the running sum
  mbd_crc u_tx_crc (
    .clk(clk),
    .rst(rst),
    .clr(state_r != S_TX),
    .en(state_r == S_TX && load && tx_i_r < rsp_len_r - 9'(CRC_LEN)),
    .din(tx_byte),
    .crc_r(tx_crc)
  );

  mbd_regs #(.NREGS(NREGS)) u_regs (
    .clk(clk),
    .rst(rst),
    .we(reg_we),
    .waddr(reg_waddr),
    .wdata(reg_wdata),
    .raddr(reg_raddr),
    .rdata(reg_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Message checks, first failure wins

  always_comb begin
    drop = 1'b0;
    err = ERR_NONE;
    if (len_r < 9'(MIN_LEN)) begin
      drop = 1'b1;
    end else if (ovf_r) begin
      err = ERR_CRC;
    end else if (fbuf[0] != SLAVE_ADDR) begin
      err = ERR_SLAVE;
    end else if (rx_crc != CRC_GOOD) begin
      err = ERR_CRC;
    end else if (!fc_known) begin
      err = ERR_FUNC;
    end else if (len_r != exp_len) begin
      err = ERR_CRC;
    end else begin
      unique case (fc)
        FC_RD_FLAG: begin
          if (num != 16'h0001) err = ERR_VALUE;
          else if (start >= NCOILS) err = ERR_ADDR;
        end
        FC_RD_BLK: begin
          if (num == 16'h0000 || num > 16'(READ_MAX)) err = ERR_VALUE;
          else if (end_adr > 17'(NREGS)) err = ERR_ADDR;
        end
        FC_WR_FLAG: begin
          if (start >= NCOILS) err = ERR_ADDR;
          else if (fdata != FLAG_TRUE && fdata != FLAG_FALSE) err = ERR_VALUE;
          else if (start == COIL_REMOTE && fdata == FLAG_TRUE && local_lock)
            err = ERR_REMOTE;
          else if (start != COIL_REMOTE && !remote_r) err = ERR_REMOTE;
        end
        FC_WR_WORD: begin
          if (start >= 16'(NREGS) || reg_acc(start) == ACC_RO) err = ERR_ADDR;
          else if (!remote_r) err = ERR_REMOTE;
        end
        default: begin
          if (num == 16'h0000 || num > 16'(WBLK_MAX) || 16'(cnt) != {num[14:0], 1'b0})
            err = ERR_VALUE;
          else if (end_adr > 17'(NREGS) || start < RO_END) err = ERR_ADDR;
          else if (!remote_r) err = ERR_REMOTE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (rx.vld && !rx.lst) state_nxt = (rx.dat >= TEXT_MIN) ? S_TXT : S_RX;
        else if (rx.vld && rx.dat < TEXT_MIN) state_nxt = S_CHK;
      end
      S_RX: if (rx.vld && rx.lst) state_nxt = S_CHK;
      S_TXT: if (rx.vld && rx.lst) state_nxt = S_IDLE;
      S_CHK: begin
        if (drop) state_nxt = S_IDLE;
        else if (err != ERR_NONE || is_read || fc == FC_WR_FLAG) state_nxt = S_TX;
        else state_nxt = S_WR;
      end
      S_WR: if (wr_last) state_nxt = S_TX;
      S_TX: if (tx_done) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      rx_busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_busy_r <= state_nxt == S_CHK || state_nxt == S_WR || state_nxt == S_TX;
    end
  end

  // Frame capture; bytes past the buffer only mark overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      len_r <= 9'h000;
      ovf_r <= 1'b0;
    end else if (take && state_r == S_IDLE) begin
      len_r <= 9'h001;
      ovf_r <= 1'b0;
      fbuf[0] <= rx.dat;
    end else if (take && state_r == S_RX) begin
      if (len_r < 9'(MAX_FRAME)) begin
        fbuf[len_r[7:0]] <= rx.dat;
        len_r <= len_r + 9'h001;
      end else begin
        ovf_r <= 1'b1;
      end
    end
  end

  // Text bytes go straight on; no reply is ever made here for them
  always_ff @(posedge clk) begin
    if (rst) begin
      txt_r <= '0;
    end else begin
      txt_r.vld <= take && (state_r == S_TXT || rx.dat >= TEXT_MIN && state_r == S_IDLE);
      txt_r.lst <= rx.lst;
      txt_r.dat <= rx.dat;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control flags; only an explicit flag write changes them

  always_ff @(posedge clk) begin
    if (rst) begin
      remote_r <= 1'b0;
      output_on_r <= 1'b0;
    end else if (ok && fc == FC_WR_FLAG) begin
      if (start == COIL_REMOTE) remote_r <= fdata == FLAG_TRUE;
      else output_on_r <= fdata == FLAG_TRUE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes, one word per cycle

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_i_r <= 16'h0000;
      wr_n_r <= 16'h0000;
      wp_r <= 9'h000;
    end else if (state_r == S_CHK) begin
      wr_i_r <= 16'h0000;
      wr_n_r <= (fc == FC_WR_BLK) ? num : 16'h0001;
      wp_r <= (fc == FC_WR_BLK) ? 9'(OFS_DAT) : 9'(OFS_NUM);
    end else if (state_r == S_WR) begin
      wr_i_r <= wr_i_r + 16'h0001;
      wp_r <= wp_r + 9'(CRC_LEN);
    end
  end

  assign reg_we = state_r == S_WR;
  assign reg_waddr = start + wr_i_r;
  assign reg_wdata = {fbuf[wp_r[7:0]], fbuf[8'(wp_r + 9'h001)]};

  //////////////////////////////////////////////////////////////////////////////
  // Reply

  always_ff @(posedge clk) begin
    if (rst) begin
      err_r <= ERR_NONE;
      rsp_len_r <= 9'h000;
    end else if (state_r == S_CHK) begin
      err_r <= err;
      if (err != ERR_NONE) rsp_len_r <= 9'(ERR_LEN);
      else if (is_read) rsp_len_r <= 9'(RSP_HDR) + {num[7:0], 1'b0} + 9'(CRC_LEN);
      else rsp_len_r <= 9'(FIX_LEN);
    end
  end

  assign didx = tx_i_r - 9'(RSP_HDR);
  assign reg_raddr = start + 16'(didx[8:1]);
  assign rd_flag_val = (start == COIL_REMOTE) ? remote_r : output_on_r;
  assign rd_word = (fc == FC_RD_FLAG) ? (rd_flag_val ? FLAG_TRUE : FLAG_FALSE)
                                      : reg_rdata;

  always_comb begin
    tx_byte = fbuf[tx_i_r[7:0]];
    if (tx_i_r == rsp_len_r - 9'(CRC_LEN)) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_i_r == rsp_len_r - 9'h001) begin
      tx_byte = tx_crc[15:8];
    end else if (tx_i_r == 9'h000) begin
      tx_byte = SLAVE_ADDR;
    end else if (err_r != ERR_NONE) begin
      tx_byte = (tx_i_r == 9'(OFS_FC)) ? (fc + EXC_FLAG) : err_r;
    end else if (is_read && tx_i_r == 9'(OFS_ADR)) begin
      tx_byte = {num[6:0], 1'b0};
    end else if (is_read && tx_i_r > 9'(OFS_ADR)) begin
      tx_byte = didx[0] ? rd_word[7:0] : rd_word[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_r <= '0;
      tx_i_r <= 9'h000;
    end else if (state_r != S_TX) begin
      tx_i_r <= 9'h000;
    end else if (load) begin
      if (tx_i_r < rsp_len_r) begin
        tx_r.vld <= 1'b1;
        tx_r.lst <= tx_i_r == rsp_len_r - 9'h001;
        tx_r.dat <= tx_byte;
        tx_i_r <= tx_i_r + 9'h001;
      end else begin
        tx_r.vld <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_go;
    state_r == S_CHK && state_nxt == S_WR;
  endsequence

  sequence s_flag_ok;
    ok && fc == FC_WR_FLAG && start == COIL_OUTPUT;
  endsequence

  a_text_routed: assert property (
    take && state_r == S_IDLE && rx.dat >= TEXT_MIN |=> txt_r.vld && txt_r.dat == $past(rx.dat)
  ) else $error("text byte not forwarded");
  a_write_remote: assert property (reg_we |-> remote_r)
    else $error("register written outside remote control");
  a_remote_refused: assert property (
    state_r == S_CHK && fc == FC_WR_FLAG && start == COIL_REMOTE && local_lock && !remote_r
    |=> !remote_r
  ) else $error("locked remote request took effect");
  a_unknown_fc: assert property (
    state_r == S_CHK && !drop && !fc_known && !ovf_r && fbuf[0] == SLAVE_ADDR
    && rx_crc == CRC_GOOD |=> state_r == S_TX && !reg_we && err_r == ERR_FUNC
  ) else $error("unknown function not rejected");
  a_err_fc: assert property (
    tx_r.vld && err_r != ERR_NONE && tx_i_r == 9'h002 |-> tx_r.dat == (fc + EXC_FLAG)
  ) else $error("error reply function code wrong");
  a_crc_last: assert property (tx_r.vld && tx_r.lst |-> tx_r.dat == tx_crc[15:8])
    else $error("checksum high byte not last");
  a_lead_zero: assert property (tx_r.vld && tx_i_r == 9'h001 |-> tx_r.dat == SLAVE_ADDR)
    else $error("reply lead byte not zero");
  a_read_len: assert property (
    state_r == S_CHK && ok && fc == FC_RD_BLK
    |=> rsp_len_r == 9'(RSP_HDR) + 9'(CRC_LEN) + {$past(num[7:0]), 1'b0}
  ) else $error("read reply length wrong");
  a_echo_len: assert property (ok && !is_read |=> rsp_len_r == 9'(FIX_LEN))
    else $error("write echo length wrong");
  a_wr_start: assert property (s_wr_go |=> reg_we && reg_waddr == $past(start))
    else $error("write does not start at address");
  a_lead_error: assert property (
    state_r == S_CHK && !drop && !ovf_r && fbuf[0] != SLAVE_ADDR |=> err_r == ERR_SLAVE
  ) else $error("bad lead byte not refused");
  // Text traffic must never provoke a reply of its own
  a_text_quiet: assert property (state_r == S_TXT |-> !tx_r.vld && !rx_busy_r)
    else $error("reply made during a text message");
  a_flag_write: assert property (
    s_flag_ok |=> output_on_r == ($past(fdata) == FLAG_TRUE)
  ) else $error("output flag not taken from whole word");
  a_busy_reply: assert property (state_r == S_TX |-> rx_busy_r)
    else $error("input open during reply");
endmodule

// file: logic/mbd_pkg.sv
// Purpose: Constants, types and helpers for the binary register message decoder.
// Assumes: Byte stream framed upstream; one byte per valid cycle, lst on final byte.
// Notes: Register map, coil numbers and error codes are local choices.
// Contract
// - Leading byte zero, taken as slave address
// - Second byte is function code, selects access
// - Flag read returns full word, FF00 true
// - Block read returns 2n data bytes
// - Flag write: whole word is one boolean
// - Word write stores one register
// - Block write may cross register block boundary
// - Queries answered, writes echoed one to one; block write echoes only its first six bytes plus checksum
// - Binary or text detected per message
// - Fields MSB first, checksum low byte first
// - Writes only while remote control active
// - Remote control entered only explicitly
// - Refused remote request changes nothing
// - Text errors never reported unasked
// - Register is 2-byte words, count halves length
// - Access attribute per register; write-only reads zero
// - Data encodings: 1, 2, 4 byte items
// - Set values fraction of nominal, CCCC full
// - Lead 1..41 errors, 42 up is text
// - Error reply: code plus 80, error, checksum
// - Checksum FFFF start, reflected A001 polynomial
package mbd_pkg;
  localparam logic [7:0] SLAVE_ADDR = 8'h00;
  localparam logic [7:0] TEXT_MIN = 8'h2A;
  localparam logic [7:0] FC_RD_FLAG = 8'h01;
  localparam logic [7:0] FC_RD_BLK = 8'h03;
  localparam logic [7:0] FC_WR_FLAG = 8'h05;
  localparam logic [7:0] FC_WR_WORD = 8'h06;
  localparam logic [7:0] FC_WR_BLK = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FUNC = 8'h01;
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_VALUE = 8'h03;
  localparam logic [7:0] ERR_SLAVE = 8'h04;
  localparam logic [7:0] ERR_CRC = 8'h05;
  localparam logic [7:0] ERR_REMOTE = 8'h06;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  localparam logic [15:0] FLAG_TRUE = 16'hFF00;
  localparam logic [15:0] FLAG_FALSE = 16'h0000;
  localparam logic [15:0] FULL_SCALE = 16'hCCCC;
  localparam logic [15:0] SET_MAX = 16'hD0E5;
  localparam logic [15:0] RO_END = 16'h0010;
  localparam logic [15:0] WO_END = 16'h0018;
  localparam logic [15:0] SET_END = 16'h0020;
  localparam logic [15:0] COIL_REMOTE = 16'h0000;
  localparam logic [15:0] COIL_OUTPUT = 16'h0001;
  localparam logic [15:0] NCOILS = 16'h0002;
  localparam int OFS_FC = 1;
  localparam int OFS_ADR = 2;
  localparam int OFS_NUM = 4;
  localparam int OFS_CNT = 6;
  localparam int OFS_DAT = 7;
  localparam int FIX_LEN = 8;
  localparam int MIN_LEN = 4;
  localparam int RSP_HDR = 3;
  localparam int CRC_LEN = 2;
  localparam int ERR_LEN = 5;
  localparam int READ_MAX = 125;
  localparam int WBLK_MAX = 123;
  localparam int MAX_FRAME = 256;
  localparam int REG_COUNT = 64;

  typedef struct packed {
    logic vld;
    logic lst;
    logic [7:0] dat;
  } mbd_byte_t;

  typedef enum logic [1:0] {ACC_RO, ACC_WO, ACC_RW} mbd_acc_t;

  // One byte into the running checksum, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic mbd_acc_t reg_acc(input logic [15:0] a);
    if (a < RO_END) return ACC_RO;
    if (a < WO_END) return ACC_WO;
    return ACC_RW;
  endfunction
endpackage

// file: logic/mbd_crc.sv
// Purpose: Running message checksum accumulator.
// Assumes: clr has priority over en.
// Notes: Residue over a frame with its checksum appended is zero.
module mbd_crc
  import mbd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and data
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc_r
);
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      crc_r <= CRC_INIT;
    end else if (en) begin
      crc_r <= crc_byte(crc_r, din);
    end
  end
endmodule

// file: logic/mbd_regs.sv
// Purpose: Register store, one 16-bit word per address.
// Assumes: Items of 1, 2 or 4 bytes occupy one or more consecutive words.
// Notes: Read is combinational; write-only and unmapped words read zero.
module mbd_regs
  import mbd_pkg::*;
#(
  parameter int NREGS = REG_COUNT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic we,
  input wire logic [15:0] waddr,
  input wire logic [15:0] wdata,
  // Read port
  input wire logic [15:0] raddr,
  output logic [15:0] rdata
);
  localparam int AW = $clog2(NREGS);
  logic [15:0] mem_r [NREGS];
  logic [15:0] wval;

  // Set values beyond the usable range are held at its top
  always_comb begin
    wval = wdata;
    if (waddr >= WO_END && waddr < SET_END && wdata > SET_MAX) begin
      wval = SET_MAX;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NREGS; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (we && waddr < 16'(NREGS)) begin
      mem_r[waddr[AW-1:0]] <= wval;
    end
  end

  always_comb begin
    if (raddr >= 16'(NREGS) || reg_acc(raddr) == ACC_WO) begin
      rdata = 16'h0000;
    end else begin
      rdata = mem_r[raddr[AW-1:0]];
    end
  end
endmodule

// file: tb/mbd_host.sv
// Purpose: Master model that sends request bytes and drains replies.
// Assumes: Drives on the falling edge; the decoder samples on the rising edge.
// Notes: Idle data shows the inverse of the last byte, so stale data never looks valid.
module mbd_host
  import mbd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests
  output mbd_byte_t rx,
  input wire logic rx_busy_r,
  // Replies
  input wire mbd_byte_t tx_r,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx = '{1'b0, 1'b0, 8'h00};
    tx_ready = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Whole message back to back, once the previous reply is out
  task automatic send(input logic [7:0] m[$]);
    int n;
    n = 0;
    while (rx_busy_r !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    foreach (m[i]) begin
      @(negedge clk);
      rx <= '{1'b1, i == m.size() - 1, m[i]};
    end
    @(negedge clk);
    rx <= '{1'b0, 1'b0, ~m[m.size() - 1]};
  endtask

  // Slow mode drops ready every other cycle to stall the reply
  task automatic recv(output logic [7:0] q[$], input bit slow, input int limit);
    bit done;
    q = {};
    done = 1'b0;
    for (int k = 0; k < limit && !done; k++) begin
      @(negedge clk);
      tx_ready <= slow ? ~tx_ready : 1'b1;
      @(posedge clk);
      if (tx_r.vld === 1'b1 && tx_ready === 1'b1) begin
        q.push_back(tx_r.dat);
        done = (tx_r.lst === 1'b1);
      end
    end
    @(negedge clk);
    tx_ready <= 1'b0;
  endtask
endmodule

// file: tb/modbus_rtu_message_decoder_bench.sv
// Purpose: Self-checking bench for the binary register message decoder.
// Assumes: Inputs change on the falling edge; replies drained by the host model.
// Notes: Checksums are computed here, independently of the design's helper.
module modbus_rtu_message_decoder_bench;
  import mbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic [7:0] mbd_bq_t[$];

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic local_lock = 1'b0;
  mbd_byte_t rx;
  mbd_byte_t tx;
  mbd_byte_t txt;
  logic rx_busy_r;
  logic tx_ready;
  logic remote_r;
  logic output_on_r;
  logic [7:0] txt_q[$];
  logic txt_last = 1'b0;
  int fails = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  mbd_decoder #(.NREGS(64)) uut (
    .clk(clk), .rst(rst), .rx(rx), .rx_busy_r(rx_busy_r), .tx_r(tx), .tx_ready(tx_ready),
    .txt_r(txt), .local_lock(local_lock), .remote_r(remote_r), .output_on_r(output_on_r)
  );

  mbd_host host (
    .clk(clk), .rx(rx), .rx_busy_r(rx_busy_r), .tx_r(tx), .tx_ready(tx_ready)
  );

  always @(posedge clk) begin
    if (txt.vld === 1'b1) begin
      txt_q.push_back(txt.dat);
      txt_last = txt.lst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected flag at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (m[i]) begin
      c ^= {8'h00, m[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  function automatic mbd_bq_t msg(input logic [7:0] a, input logic [7:0] b,
                                  input logic [15:0] c, input logic [15:0] d);
    return '{a, b, c[15:8], c[7:0], d[15:8], d[7:0]};
  endfunction

  // Bad flips one checksum bit to provoke a refusal
  task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$], input bit slow,
                      input bit bad);
    logic [7:0] got[$];
    logic [15:0] c;
    c = crc16(req) ^ {15'h0000, bad};
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    c = crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    host.send(req);
    host.recv(got, slow, 600);
    check_val(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      check_val(i < got.size() ? {8'h00, got[i]} : 16'hFFFF, {8'h00, exp[i]});
    end
  endtask

  task automatic wr(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
    xact(msg(8'h00, fc, a, v), msg(8'h00, fc, a, v), 1'b0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
    xact(msg(8'h00, fc, a, 16'h0001), '{8'h00, fc, 8'h02, v[15:8], v[7:0]}, 1'b0, 1'b0);
  endtask

  task automatic er(input logic [7:0] ld, input logic [7:0] fc, input logic [15:0] a,
                    input logic [15:0] v, input logic [7:0] code, input bit bad);
    xact(msg(ld, fc, a, v), '{8'h00, fc + EXC_FLAG, code}, 1'b0, bad);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    check_flag(remote_r, 1'b0);
    check_flag(output_on_r, 1'b0);
    check_flag(tx.vld, 1'b0);
    check_flag(rx_busy_r, 1'b0);
  endtask

  task automatic s_guard();
    er(8'h00, FC_WR_WORD, 16'h0020, 16'h1234, ERR_REMOTE, 1'b0);
    rd(FC_RD_BLK, 16'h0020, 16'h0000);
    @(negedge clk) local_lock = 1'b1;
    er(8'h00, FC_WR_FLAG, COIL_REMOTE, FLAG_TRUE, ERR_REMOTE, 1'b0);
    check_flag(remote_r, 1'b0);
    @(negedge clk) local_lock = 1'b0;
    er(8'h00, FC_WR_FLAG, COIL_REMOTE, 16'h1234, ERR_VALUE, 1'b0);
    wr(FC_WR_FLAG, COIL_REMOTE, FLAG_TRUE);
    check_flag(remote_r, 1'b1);
  endtask

  task automatic s_words();
    wr(FC_WR_WORD, 16'h0020, 16'h1234);
    rd(FC_RD_BLK, 16'h0020, 16'h1234);
    wr(FC_WR_WORD, 16'h0010, 16'h5555);
    rd(FC_RD_BLK, 16'h0010, 16'h0000);
    wr(FC_WR_WORD, 16'h0018, 16'hFFFF);
    rd(FC_RD_BLK, 16'h0018, SET_MAX);
    // Crosses from the set value block into the read-write block
    xact('{8'h00, 8'h10, 8'h00, 8'h1E, 8'h00, 8'h04, 8'h08, 8'h00, 8'h01, 8'h00, 8'h02,
           8'h00, 8'h03, 8'h00, 8'h04}, msg(8'h00, FC_WR_BLK, 16'h001E, 16'h0004),
         1'b0, 1'b0);
    xact(msg(8'h00, FC_RD_BLK, 16'h001E, 16'h0004), '{8'h00, 8'h03, 8'h08, 8'h00, 8'h01,
         8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h04}, 1'b1, 1'b0);
  endtask

  task automatic s_coil();
    wr(FC_WR_FLAG, COIL_OUTPUT, FLAG_TRUE);
    check_flag(output_on_r, 1'b1);
    rd(FC_RD_FLAG, COIL_OUTPUT, FLAG_TRUE);
    wr(FC_WR_FLAG, COIL_OUTPUT, FLAG_FALSE);
    rd(FC_RD_FLAG, COIL_OUTPUT, FLAG_FALSE);
    check_flag(output_on_r, 1'b0);
    wr(FC_WR_FLAG, COIL_REMOTE, FLAG_FALSE);
    check_flag(remote_r, 1'b0);
  endtask

  task automatic s_errors();
    logic [7:0] bad_fc[4];
    logic [7:0] got[$];
    bad_fc = '{8'h02, 8'h04, 8'h0F, 8'h7F};
    er(8'h00, FC_WR_WORD, 16'h0005, 16'h1234, ERR_ADDR, 1'b0);
    er(8'h01, FC_RD_BLK, 16'h0020, 16'h0001, ERR_SLAVE, 1'b0);
    er(8'h29, FC_RD_BLK, 16'h0020, 16'h0001, ERR_SLAVE, 1'b0);
    foreach (bad_fc[i]) begin
      er(8'h00, bad_fc[i], 16'h0020, 16'h0001, ERR_FUNC, 1'b0);
    end
    // Block write left 0003 here; a refused function must not touch it
    rd(FC_RD_BLK, 16'h0020, 16'h0003);
    er(8'h00, FC_RD_BLK, 16'h0020, 16'h0001, ERR_CRC, 1'b1);
    // Shorter than the four-byte minimum: dropped without reply
    got = '{8'h00, 8'h03};
    host.send(got);
    host.recv(got, 1'b0, 20);
    check_val(16'(got.size()), 16'h0000);
  endtask

  task automatic s_text();
    logic [7:0] got[$];
    logic [7:0] m[$];
    m = '{8'h2A, 8'h3F, 8'h0A};
    txt_q = {};
    host.send(m);
    host.recv(got, 1'b0, 20);
    check_val(16'(got.size()), 16'h0000);
    check_val(16'(txt_q.size()), 16'h0003);
    check_flag(txt_last, 1'b1);
    foreach (m[i]) begin
      check_val(i < txt_q.size() ? {8'h00, txt_q[i]} : 16'hFFFF, {8'h00, m[i]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    s_reset();
    s_guard();
    s_words();
    s_coil();
    s_errors();
    s_text();
    complete_run();
  end

  // Whole sequence needs under a thousand cycles
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
